// [pxh_defines.svh]
// register map, field positions, reset values and limits of the pixel histogram binner
`ifndef PXH_DEFINES_SVH
`define PXH_DEFINES_SVH

`define PXH_ADDR_W 13
`define PXH_PIX_W 16
`define PXH_CNT_W 20
`define PXH_MEM_AW 10
`define PXH_CNT_MAX 20'hFFFFF

`define PXH_OFS_CTRL 13'h0000
`define PXH_OFS_STATUS 13'h0004
`define PXH_OFS_REG0_H 13'h0010
`define PXH_OFS_REG0_V 13'h0014
`define PXH_OFS_REG1_H 13'h0018
`define PXH_OFS_REG1_V 13'h001C
`define PXH_OFS_REG2_H 13'h0020
`define PXH_OFS_REG2_V 13'h0024
`define PXH_OFS_REG3_H 13'h0028
`define PXH_OFS_REG3_V 13'h002C
`define PXH_HIST_BIT 12

`define PXH_CTRL_EN 0
`define PXH_CTRL_SRC 1
`define PXH_CTRL_COR 2
`define PXH_CTRL_BINS_LO 3
`define PXH_CTRL_SHIFT_LO 5
`define PXH_CTRL_NREG_LO 8
`define PXH_CTRL_FOURCOL 10
`define PXH_CTRL_RST 32'h00000400
`define PXH_WIN_RST 32'h00000000

`endif

// [pxh_pkg.sv]
// types shared by the pixel histogram binner
package pxh_pkg;

  typedef enum logic [1:0] {
    PXH_S_IDLE = 2'b00,
    PXH_S_INC = 2'b01,
    PXH_S_HRD = 2'b10
  } pxh_state_t;

  typedef enum logic [1:0] {
    PXH_BINS_32 = 2'b00,
    PXH_BINS_64 = 2'b01,
    PXH_BINS_128 = 2'b10,
    PXH_BINS_256 = 2'b11
  } pxh_bins_t;

endpackage : pxh_pkg

// [pxh_buf2.sv]
// two-entry stream buffer with registered input ready
`timescale 1ns/1ns
module pxh_buf2 #(
  parameter int WIDTH = 18
) (
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  input wire logic i_in_valid,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_in_ready,
  output logic o_out_valid,
  output logic [WIDTH-1:0] o_out_data,
  input wire logic i_out_ready
);
  logic [WIDTH-1:0] slot [0:1];
  logic wr_ptr;
  logic rd_ptr;
  logic [1:0] count;
  logic next_wr_ptr;
  logic next_rd_ptr;
  logic [1:0] next_count;
  logic push;
  logic pop;

  always_comb begin
    push = i_in_valid & o_in_ready;
    pop = o_out_valid & i_out_ready;
    next_wr_ptr = push ? ~wr_ptr : wr_ptr;
    next_rd_ptr = pop ? ~rd_ptr : rd_ptr;
    next_count = count;
    if (push && !pop) begin
      next_count = count + 2'h1;
    end else if (pop && !push) begin
      next_count = count - 2'h1;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      count <= 2'h0;
      o_in_ready <= 1'b0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
      o_in_ready <= (next_count != 2'h2);
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (push) begin
      slot[wr_ptr] <= i_in_data;
    end
  end

  assign o_out_valid = (count != 2'h0);
  assign o_out_data = slot[rd_ptr];
endmodule : pxh_buf2

// [pxh_binner.sv]
// pixel histogram binner: raw pixel stream into per-region, per-colour bins, APB readout
`timescale 1ns/1ns
`include "pxh_defines.svh"

module pxh_binner (
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [`PXH_ADDR_W-1:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic i_ccdc_valid,
  input wire logic [`PXH_PIX_W-1:0] i_ccdc_pixel,
  input wire logic i_ccdc_sof,
  input wire logic i_ccdc_eol,
  output logic o_ccdc_ready,
  input wire logic i_mem_valid,
  input wire logic [`PXH_PIX_W-1:0] i_mem_pixel,
  input wire logic i_mem_sof,
  input wire logic i_mem_eol,
  output logic o_mem_ready
);
  localparam int DW = `PXH_PIX_W + 2;

  logic [31:0] ctrl;
  logic [31:0] win_h [0:3];
  logic [31:0] win_v [0:3];
  logic [31:0] next_ctrl;
  logic [31:0] next_win_h [0:3];
  logic [31:0] next_win_v [0:3];
  logic [31:0] next_prdata;
  logic next_pready;
  logic next_pslverr;

  pxh_pkg::pxh_state_t state;
  pxh_pkg::pxh_state_t next_state;
  logic [`PXH_MEM_AW-1:0] addr_q;
  logic [`PXH_MEM_AW-1:0] next_addr_q;
  logic [15:0] cur_col;
  logic [15:0] cur_line;
  logic [15:0] next_col;
  logic [15:0] next_line;

  logic [`PXH_CNT_W-1:0] hist_mem [0:(1<<`PXH_MEM_AW)-1];
  logic [`PXH_CNT_W-1:0] mem_rdata;
  logic [`PXH_MEM_AW-1:0] mem_addr;
  logic mem_we;
  logic [`PXH_CNT_W-1:0] mem_wdata;

  logic [1:0] src_valid;
  logic [1:0] src_ready;
  logic [DW-1:0] src_data [0:1];
  logic [1:0] buf_in_ready;
  logic [DW-1:0] buf_in_data [0:1];
  logic [1:0] buf_in_valid;

  logic sel;
  logic pix_valid;
  logic [`PXH_PIX_W-1:0] pix;
  logic pix_sof;
  logic pix_eol;
  logic pix_pop;
  logic [15:0] px_col;
  logic [15:0] px_line;
  logic [3:0] in_win;
  logic [1:0] region;
  logic hit;
  logic [1:0] colour;
  logic [3:0] bin_bits;
  logic [`PXH_PIX_W-1:0] shifted;
  logic [`PXH_PIX_W-1:0] last_bin;
  logic [7:0] bin;
  logic [11:0] pix_addr;
  logic access;
  logic hist_acc;
  logic [2:0] nreg;

  assign buf_in_valid = {i_mem_valid, i_ccdc_valid};
  assign buf_in_data[0] = {i_ccdc_sof, i_ccdc_eol, i_ccdc_pixel};
  assign buf_in_data[1] = {i_mem_sof, i_mem_eol, i_mem_pixel};
  assign o_ccdc_ready = buf_in_ready[0];
  assign o_mem_ready = buf_in_ready[1];

  // one buffer per source so each ready stays a flop; the unselected one simply stalls
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_src
      pxh_buf2 #(.WIDTH(DW)) u_buf (
        .i_ref_clk(i_ref_clk),
        .i_sys_rst(i_sys_rst),
        .i_in_valid(buf_in_valid[gi]),
        .i_in_data(buf_in_data[gi]),
        .o_in_ready(buf_in_ready[gi]),
        .o_out_valid(src_valid[gi]),
        .o_out_data(src_data[gi]),
        .i_out_ready(src_ready[gi])
      );
    end
  endgenerate

  // pixel decode: position, region, colour, bin
  always_comb begin
    sel = ctrl[`PXH_CTRL_SRC];
    pix_valid = src_valid[sel];
    {pix_sof, pix_eol, pix} = src_data[sel];
    px_col = pix_sof ? 16'h0000 : cur_col;
    px_line = pix_sof ? 16'h0000 : cur_line;
    nreg = {1'b0, ctrl[`PXH_CTRL_NREG_LO +: 2]} + 3'h1;
    for (int r = 0; r < 4; r++) begin
      in_win[r] = (r < int'(nreg)) &&
                  (px_col >= win_h[r][15:0]) && (px_col <= win_h[r][31:16]) &&
                  (px_line >= win_v[r][15:0]) && (px_line <= win_v[r][31:16]);
    end
    hit = |in_win;
    region = 2'h3;
    if (in_win[0]) begin
      region = 2'h0;
    end else if (in_win[1]) begin
      region = 2'h1;
    end else if (in_win[2]) begin
      region = 2'h2;
    end
    colour = {px_line[0], px_col[0]};
    if (!ctrl[`PXH_CTRL_FOURCOL]) begin
      // three-colour mode merges the two greens of the cell
      colour = (colour == 2'h3) ? 2'h2 : ((colour == 2'h2) ? 2'h1 : colour);
    end
    bin_bits = 4'h5 + {2'h0, ctrl[`PXH_CTRL_BINS_LO +: 2]};
    shifted = pix >> ctrl[`PXH_CTRL_SHIFT_LO +: 3];
    last_bin = (16'h0001 << bin_bits) - 16'h0001;
    bin = (shifted >= last_bin) ? last_bin[7:0] : shifted[7:0];
    pix_addr = ({8'h00, region, colour} << bin_bits) | {4'h0, bin};
  end

  // histogram update and host readout share one memory port
  always_comb begin
    access = i_psel & i_penable & ~o_pready;
    hist_acc = access & i_paddr[`PXH_HIST_BIT];
    next_state = state;
    next_addr_q = addr_q;
    next_col = cur_col;
    next_line = cur_line;
    mem_addr = addr_q;
    mem_we = 1'b0;
    mem_wdata = mem_rdata;
    pix_pop = 1'b0;
    src_ready = 2'b00;
    unique case (state)
      pxh_pkg::PXH_S_IDLE: begin
        if (hist_acc) begin
          mem_addr = i_paddr[2 +: `PXH_MEM_AW];
          next_addr_q = mem_addr;
          next_state = pxh_pkg::PXH_S_HRD;
        end else if (pix_valid) begin
          pix_pop = 1'b1;
          next_col = pix_eol ? 16'h0000 : px_col + 16'h0001;
          next_line = pix_eol ? px_line + 16'h0001 : px_line;
          mem_addr = pix_addr[`PXH_MEM_AW-1:0];
          next_addr_q = mem_addr;
          if (ctrl[`PXH_CTRL_EN] && hit) begin
            next_state = pxh_pkg::PXH_S_INC;
          end
        end
      end
      pxh_pkg::PXH_S_INC: begin
        mem_we = 1'b1;
        // count only, pixel value discarded, saturating at full scale
        mem_wdata = (mem_rdata == `PXH_CNT_MAX) ? mem_rdata : mem_rdata + 20'h00001;
        next_state = pxh_pkg::PXH_S_IDLE;
      end
      pxh_pkg::PXH_S_HRD: begin
        mem_we = ctrl[`PXH_CTRL_COR];
        mem_wdata = 20'h00000;
        next_state = pxh_pkg::PXH_S_IDLE;
      end
      default: begin
        next_state = pxh_pkg::PXH_S_IDLE;
      end
    endcase
    src_ready[sel] = pix_pop;
  end

  always_ff @(posedge i_ref_clk) begin
    if (mem_we) begin
      hist_mem[mem_addr] <= mem_wdata;
    end
    mem_rdata <= hist_mem[mem_addr];
  end

  // apb register slave
  always_comb begin
    next_ctrl = ctrl;
    for (int r = 0; r < 4; r++) begin
      next_win_h[r] = win_h[r];
      next_win_v[r] = win_v[r];
    end
    next_pready = 1'b0;
    next_pslverr = 1'b0;
    next_prdata = 32'h00000000;
    if (state == pxh_pkg::PXH_S_HRD) begin
      next_pready = 1'b1;
      next_pslverr = i_pwrite;
      next_prdata = {12'h000, mem_rdata};
    end else if (access && !i_paddr[`PXH_HIST_BIT]) begin
      next_pready = 1'b1;
      if (i_paddr == `PXH_OFS_CTRL) begin
        if (i_pwrite) begin
          next_ctrl = {21'h000000, i_pwdata[10:0]};
        end
        next_prdata = ctrl;
      end else if (i_paddr == `PXH_OFS_STATUS) begin
        next_pslverr = i_pwrite;
        next_prdata = {cur_line, 14'h0000, pix_valid, (state != pxh_pkg::PXH_S_IDLE)};
      end else if (i_paddr >= `PXH_OFS_REG0_H && i_paddr <= `PXH_OFS_REG3_V &&
                   i_paddr[1:0] == 2'h0) begin
        for (int r = 0; r < 4; r++) begin
          if (i_paddr[4:3] == 2'(r + 2) && !i_paddr[2]) begin
            if (i_pwrite) begin
              next_win_h[r] = i_pwdata;
            end
            next_prdata = win_h[r];
          end
          if (i_paddr[4:3] == 2'(r + 2) && i_paddr[2]) begin
            if (i_pwrite) begin
              next_win_v[r] = i_pwdata;
            end
            next_prdata = win_v[r];
          end
        end
      end else begin
        next_pslverr = 1'b1;
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      ctrl <= `PXH_CTRL_RST;
      for (int r = 0; r < 4; r++) begin
        win_h[r] <= `PXH_WIN_RST;
        win_v[r] <= `PXH_WIN_RST;
      end
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata <= 32'h00000000;
      state <= pxh_pkg::PXH_S_IDLE;
      addr_q <= 10'h000;
      cur_col <= 16'h0000;
      cur_line <= 16'h0000;
    end else begin
      ctrl <= next_ctrl;
      for (int r = 0; r < 4; r++) begin
        win_h[r] <= next_win_h[r];
        win_v[r] <= next_win_v[r];
      end
      o_pready <= next_pready;
      o_pslverr <= next_pslverr;
      o_prdata <= next_prdata;
      state <= next_state;
      addr_q <= next_addr_q;
      cur_col <= next_col;
      cur_line <= next_line;
    end
  end
endmodule : pxh_binner

// [pxh_binner_chk.sv]
// port assertions for the pixel histogram binner
`timescale 1ns/1ns
`include "pxh_defines.svh"
module pxh_binner_chk (
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [`PXH_ADDR_W-1:0] i_paddr,
  input wire logic [31:0] o_prdata,
  input wire logic o_pready,
  input wire logic o_pslverr,
  input wire logic o_ccdc_ready,
  input wire logic o_mem_ready
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_sys_rst);
  property p_one_beat; o_pready |=> !o_pready; endproperty
  a_one_beat: assert property (p_one_beat) else $error("ready held too long");
  property p_in_access; o_pready |-> i_psel && i_penable; endproperty
  a_in_access: assert property (p_in_access) else $error("ready outside access");
  property p_bound; i_psel && i_penable && !o_pready |-> ##[1:3] o_pready; endproperty
  a_bound: assert property (p_bound) else $error("answer too late");
  property p_reg_fast; $rose(i_penable) && i_psel && !i_paddr[12] |=> o_pready; endproperty
  a_reg_fast: assert property (p_reg_fast) else $error("register answer late");
  property p_idle_data; !o_pready |-> o_prdata == 32'h00000000; endproperty
  a_idle_data: assert property (p_idle_data) else $error("data outside answer");
  property p_err_beat; o_pslverr |-> o_pready; endproperty
  a_err_beat: assert property (p_err_beat) else $error("error without ready");
  property p_hist_ro; o_pready && i_paddr[12] && i_pwrite |-> o_pslverr; endproperty
  a_hist_ro: assert property (p_hist_ro) else $error("count write accepted");
  property p_width; o_pready && i_paddr[12] && !i_pwrite |-> o_prdata[31:20] == 12'h000;
  endproperty
  a_width: assert property (p_width) else $error("count wider than field");
  property p_ccdc_wake; $fell(i_sys_rst) |-> !o_ccdc_ready ##1 o_ccdc_ready; endproperty
  a_ccdc_wake: assert property (p_ccdc_wake) else $error("sensor ready wrong");
  property p_mem_wake; $fell(i_sys_rst) |-> !o_mem_ready ##1 o_mem_ready; endproperty
  a_mem_wake: assert property (p_mem_wake) else $error("memory ready wrong");
endmodule : pxh_binner_chk

// [pxh_src.sv]
// raw pixel source standing in for the sensor controller or memory read-back
`timescale 1ns/1ns
module pxh_src (
  input wire logic i_ref_clk,
  input wire logic i_ready,
  output logic o_valid,
  output logic [15:0] o_pixel,
  output logic o_sof,
  output logic o_eol
);
  initial begin
    o_valid = 1'b0;
    o_pixel = 16'h0000;
    o_sof = 1'b0;
    o_eol = 1'b0;
  end
  // idle lines show the inverse so stale data never looks valid
  task send(input logic [15:0] p, input logic s, input logic e, input int gap);
    if (gap > 0) begin
      o_valid <= 1'b0;
      o_pixel <= ~o_pixel;
      repeat (gap) @(posedge i_ref_clk);
    end
    o_valid <= 1'b1;
    o_pixel <= p;
    o_sof <= s;
    o_eol <= e;
    @(posedge i_ref_clk);
    while (!i_ready) @(posedge i_ref_clk);
  endtask : send
  task done();
    o_valid <= 1'b0;
    o_pixel <= ~o_pixel;
    o_sof <= 1'b0;
    o_eol <= 1'b0;
  endtask : done
endmodule : pxh_src

// [pxh_binner_bench.sv]
// self-checking bench for the pixel histogram binner
`timescale 1ns/1ns
`include "pxh_defines.svh"
module pxh_binner_bench;
  logic i_ref_clk, i_sys_rst, psel, penable, pwrite, pready, pslverr, er;
  logic [`PXH_ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic cv, cs, ce, cr, mv, ms, me, mr;
  logic [15:0] cp, mp;
  int n_mismatch, n_compared, cyc, c, b, r, col, ln, nb, sh;
  int expc [1024];
  // per pass: bins per colour, downshift, regions in use and control word
  int nbv [3] = '{32, 32, 64};
  int shv [3] = '{3, 3, 2};
  int nrv [3] = '{2, 2, 4};
  logic [31:0] cfg [3] = '{32'h00000565, 32'h00000167, 32'h0000074D};
  logic [15:0] pix [10] = '{16'h0005, 16'h0100, 16'h00F8, 16'hFFFF, 16'h0010,
    16'h0040, 16'h0008, 16'h00F7, 16'h0000, 16'h0030};
  pxh_binner uut (.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .i_ccdc_valid(cv),
    .i_ccdc_pixel(cp), .i_ccdc_sof(cs), .i_ccdc_eol(ce), .o_ccdc_ready(cr),
    .i_mem_valid(mv), .i_mem_pixel(mp), .i_mem_sof(ms), .i_mem_eol(me), .o_mem_ready(mr));
  pxh_src src_c (.i_ref_clk(i_ref_clk), .i_ready(cr), .o_valid(cv), .o_pixel(cp),
    .o_sof(cs), .o_eol(ce));
  pxh_src src_m (.i_ref_clk(i_ref_clk), .i_ready(mr), .o_valid(mv), .o_pixel(mp),
    .o_sof(ms), .o_eol(me));
  initial begin
    i_ref_clk = 1'b0;
    forever #5 i_ref_clk = ~i_ref_clk;
  end
  task chk(input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, s, e);
    end
  endtask : chk
  task apb(input logic w, input logic [`PXH_ADDR_W-1:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge i_ref_clk);
    penable <= 1'b1;
    @(posedge i_ref_clk);
    while (!pready) @(posedge i_ref_clk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge i_ref_clk);
  endtask : apb
  task finish_test();
    $display("compared %0d, mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : finish_test
  always @(posedge i_ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      n_mismatch++;
      finish_test();
    end
  end
  initial begin
    i_sys_rst = 1'b1;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    repeat (10) @(posedge i_ref_clk);
    i_sys_rst <= 1'b0;
    @(posedge i_ref_clk);
    apb(1'b0, `PXH_OFS_CTRL, 32'h0);
    chk(rd, `PXH_CTRL_RST);
    apb(1'b0, 13'h0008, 32'h0);
    chk({31'h0, er}, 32'h1);
    apb(1'b1, `PXH_OFS_REG0_H, 32'h00020001);
    apb(1'b1, `PXH_OFS_REG0_V, 32'h00010000);
    apb(1'b1, `PXH_OFS_REG1_H, 32'h00030000);
    apb(1'b1, `PXH_OFS_REG1_V, 32'h00010000);
    apb(1'b1, `PXH_OFS_REG2_H, 32'h00040004);
    apb(1'b1, `PXH_OFS_REG2_V, 32'h00000000);
    apb(1'b1, `PXH_OFS_REG3_H, 32'h00040000);
    apb(1'b1, `PXH_OFS_REG3_V, 32'h00010000);
    apb(1'b0, `PXH_OFS_REG3_V, 32'h0);
    chk(rd, 32'h00010000);
    apb(1'b1, `PXH_OFS_STATUS, 32'h0);
    chk({31'h0, er}, 32'h1);
    apb(1'b1, 13'h1000, 32'h5);
    chk({31'h0, er}, 32'h1);
    $display("register test done");
    for (int m = 0; m < 3; m++) begin
      // pass 0 sensor; 1 memory, three colours; 2 sensor, four regions, 64 bins, shift 2
      nb = nbv[m];
      sh = shv[m];
      apb(1'b1, `PXH_OFS_CTRL, cfg[m]);
      for (int i = 0; i < nrv[m] * 4 * nb; i++) begin
        apb(1'b0, {1'b1, 10'(i), 2'b00}, 32'h0);
        expc[i] = 0;
      end
      for (int i = 0; i < 10; i++) begin
        col = i % 5;
        ln = i / 5;
        b = pix[i] >> sh;
        if (b > nb - 1) b = nb - 1;
        c = (ln % 2) * 2 + col % 2;
        if (m == 1 && c > 1) c = c - 1;
        r = (col >= 1 && col <= 2) ? 0 : (col <= 3 ? 1 : (nrv[m] > 2 ? 2 + ln : -1));
        if (r >= 0) expc[(r * 4 + c) * nb + b]++;
        if (m != 1) src_c.send(pix[i], i == 0, col == 4, i % 3);
        else src_m.send(pix[i], i == 0, col == 4, i % 3);
      end
      if (m != 1) src_c.done();
      else src_m.done();
      rd = 32'h1;
      while (rd[1:0] != 2'b00) apb(1'b0, `PXH_OFS_STATUS, 32'h0);
      for (int i = 0; i < nrv[m] * 4 * nb; i++) begin
        apb(1'b0, {1'b1, 10'(i), 2'b00}, 32'h0);
        chk(rd, 32'(expc[i]));
      end
      apb(1'b0, 13'h1200, 32'h0);
      chk(rd, 32'h0);
      $display("histogram pass %0d done", m);
    end
    finish_test();
  end
endmodule : pxh_binner_bench
bind pxh_binner pxh_binner_chk chk (.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst),
  .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
  .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
  .o_ccdc_ready(o_ccdc_ready), .o_mem_ready(o_mem_ready));
